// ### gppi_defines.vh
// Purpose: constants for the general purpose port with pixel input
// Assumes: byte addresses on a 9-bit register port, 32-bit data words
// Notes:   data window occupies words 0..63, control words follow it
`ifndef GPPI_DEFINES_VH
`define GPPI_DEFINES_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define GPPI_ADDR_W        9
`define GPPI_WIN_BASE      9'h000
`define GPPI_WIN_WORDS     64
`define GPPI_CTRL_ADDR     9'h100
`define GPPI_OE_ADDR       9'h104
`define GPPI_STAT_ADDR     9'h108

// ****************************************
// fields and reset values
// ****************************************
`define GPPI_PINS          24
`define GPPI_OE_RST        24'h000000
`define GPPI_MODE_NORMAL   2'h0
`define GPPI_MODE_PIX_IN   2'h1
`define GPPI_CTRL_MODE_LO  0
`define GPPI_CTRL_INV_BIT  2
`define GPPI_CTRL_EDGE_BIT 3
`define GPPI_STAT_INT_BIT  0
`define GPPI_STAT_OVF_BIT  1
`define GPPI_STAT_EMP_BIT  2

// ****************************************
// pixel input pin positions
// ****************************************
`define GPPI_PIN_LSTART    23
`define GPPI_PIN_FSTART    22
`define GPPI_PIN_LACT      21
`define GPPI_PIN_VALID     20
`define GPPI_PIN_CB        19
`define GPPI_PIN_PARITY    18
`define GPPI_PIN_FACT      17
`define GPPI_PIN_IRQ       8
`define GPPI_PIX_W         20
`define GPPI_FIFO_DEPTH    16
`define GPPI_FIFO_AW       4

`endif

// ### gppi_top.v
// Purpose: 24-pin general purpose port with synchronous pixel input
// Assumes: CLK_I 10 MHz, port clock far slower and sampled as data
// Notes:   pixel words leave through a 16-word FIFO with valid/ready
`timescale 1ns/1ps
`include "gppi_defines.vh"

// ****************************************
// pixel FIFO
// ****************************************
module gppi_fifo #(
   parameter WIDTH = 20,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_i,     // system clock
   input  wire             rst_i,     // async reset, high
   input  wire [WIDTH-1:0] in_data_i, // push data
   input  wire             in_valid_i,// push request
   output wire             in_ready_o,// not full
   output wire [WIDTH-1:0] out_data_o,// head word
   output wire             out_valid_o,// not empty
   input  wire             out_ready_i // pop request
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr_reg;
   reg [AW:0]      rd_ptr_reg;
   wire            full;
   wire            empty;

   // extra pointer bit tells full from empty
   assign full        = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
   assign empty       = (wr_ptr_reg == rd_ptr_reg);
   assign in_ready_o  = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];

   // storage has no reset, only pointers do
   always @(posedge clk_i) begin
      if (in_valid_i && !full) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
      end
   end

   // pointer advance
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (in_valid_i && !full) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_ready_i && !empty) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

// ****************************************
// port top
// ****************************************
// Behaviour
// - pins configured one by one; one mode selector governs whole port.
// - mode value 00 is normal mode and the reset default.
// - 24-bit output enable mask, 1 drives the pin, 0 makes input.
// - enable mask resets to zero, all pins three-stated.
// - data window writes land in holding register, driven on enabled pins.
// - reading a disabled pin returns its buffered pin level.
// - data bits written while their enable is zero are dropped.
// - reading an enabled pin returns the holding register bit.
// - normal mode data window spans 64 contiguous words.
// - only the low 24 bits of each word reach the pins.
// - pin 8 requests interrupt and drives the port interrupt status.
// - invert option flips the interrupt pin right after its buffer.
// - edge option off passes level; on sets status on rising edge.
// - pixel input mode takes 16-bit luma/chroma, bypassing processing.
// - source supplies port clock; inputs sampled on its rising edge.
// - pin 21 line active flag marks nonblanking pixels in a line.
// - pixel accepted only while pin 20 valid qualifier is high.
// - pin 19 high marks blue chroma; grounded if not luma/chroma.
// - pin 17 field active flag marks vertically nonblanking pixels.
// - luma on pins 15 to 8, chroma on 7 to 0, pin 16 ground.
module gppi_top (
   input  wire        CLK_I,        // system clock, 10 MHz
   input  wire        RST_I,        // async reset, active high
   input  wire [8:0]  REG_ADDR_I,   // register byte address
   input  wire        REG_WR_I,     // write strobe, one cycle
   input  wire        REG_RD_I,     // read strobe, one cycle
   input  wire [31:0] REG_WDATA_I,  // write data
   output reg  [31:0] REG_RDATA_O,  // read data
   output reg         REG_RVALID_O, // read data valid pulse
   input  wire [23:0] GPIO_I,       // pin levels from pad buffers
   output reg  [23:0] GPIO_O,       // pin drive values
   output reg  [23:0] GPIO_OE_O,    // pin output enables, high drives
   input  wire        PCLK_I,       // port clock from video source
   output reg  [19:0] PIX_DATA_O,   // pixel word toward video path
   output reg         PIX_VALID_O,  // pixel word valid
   input  wire        PIX_READY_I,  // video path takes word
   output reg         PORT_INT_O    // port interrupt status bit
);
   reg  [23:0] pin_meta_reg;
   reg  [23:0] pin_sync_reg;
   reg  [23:0] pin_hold_reg;
   reg  [2:0]  pclk_sh_reg;
   reg  [1:0]  mode_reg;
   reg         inv_reg;
   reg         edge_reg;
   reg  [23:0] oe_reg;
   reg  [23:0] hold_reg;
   reg         irq_prev_reg;
   reg         int_stat_reg;
   reg         ovf_reg;
   reg         lstart_prev_reg;
   reg         fstart_prev_reg;
   reg         sol_reg;
   reg         sof_reg;
   wire        pclk_rise;
   wire        win_hit;
   wire        wr_win;
   wire        irq_in;
   wire        pix_mode;
   wire        take_pix;
   wire [19:0] push_word;
   wire        fifo_ready;
   wire [19:0] fifo_data;
   wire        fifo_valid;
   wire        fifo_pop;
   wire [23:0] read_pins;
   wire        ovf_clr;
   wire        int_clr;

   // ****************************************
   // input synchronisers
   // ****************************************
   // pins and port clock cross into CLK_I through two flops each
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pin_meta_reg <= 24'h000000;
         pin_sync_reg <= 24'h000000;
         pin_hold_reg <= 24'h000000;
         pclk_sh_reg  <= 3'h0;
      end else begin
         pin_meta_reg <= GPIO_I;
         pin_sync_reg <= pin_meta_reg;
         pin_hold_reg <= pin_sync_reg;
         pclk_sh_reg  <= {pclk_sh_reg[1:0], PCLK_I};
      end
   end

   // pin_hold lines up with the third port clock stage
   assign pclk_rise = pclk_sh_reg[1] & ~pclk_sh_reg[2];

   // ****************************************
   // register decode
   // ****************************************
   assign win_hit  = (REG_ADDR_I[8] == 1'b0) && (REG_ADDR_I[1:0] == 2'h0);
   assign wr_win   = REG_WR_I && win_hit && (mode_reg == `GPPI_MODE_NORMAL);
   assign pix_mode = (mode_reg == `GPPI_MODE_PIX_IN);
   assign int_clr  = REG_WR_I && (REG_ADDR_I == `GPPI_STAT_ADDR) && REG_WDATA_I[`GPPI_STAT_INT_BIT];
   assign ovf_clr  = REG_WR_I && (REG_ADDR_I == `GPPI_STAT_ADDR) && REG_WDATA_I[`GPPI_STAT_OVF_BIT];

   // control and enable mask; mode covers the whole port
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mode_reg <= `GPPI_MODE_NORMAL;
         inv_reg  <= 1'b0;
         edge_reg <= 1'b0;
         oe_reg   <= `GPPI_OE_RST;
      end else begin
         if (REG_WR_I && (REG_ADDR_I == `GPPI_CTRL_ADDR)) begin
            mode_reg <= REG_WDATA_I[`GPPI_CTRL_MODE_LO+1:`GPPI_CTRL_MODE_LO];
            inv_reg  <= REG_WDATA_I[`GPPI_CTRL_INV_BIT];
            edge_reg <= REG_WDATA_I[`GPPI_CTRL_EDGE_BIT];
         end
         if (REG_WR_I && (REG_ADDR_I == `GPPI_OE_ADDR)) begin
            oe_reg <= REG_WDATA_I[23:0];
         end
      end
   end

   // ****************************************
   // holding register and read mux, per pin
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < `GPPI_PINS; gi = gi + 1) begin : g_pin
         // a bit written while its driver is off is simply not kept
         always @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
               hold_reg[gi] <= 1'b0;
            end else if (wr_win && oe_reg[gi]) begin
               hold_reg[gi] <= REG_WDATA_I[gi];
            end
         end
         assign read_pins[gi] = oe_reg[gi] ? hold_reg[gi] : pin_sync_reg[gi];
      end
   endgenerate

   // ****************************************
   // pin drive
   // ****************************************
   // pixel and unbuilt modes release every pin, avoiding contention
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         GPIO_O    <= 24'h000000;
         GPIO_OE_O <= 24'h000000;
      end else begin
         GPIO_O    <= hold_reg;
         GPIO_OE_O <= (mode_reg == `GPPI_MODE_NORMAL) ? oe_reg : 24'h000000;
      end
   end

   // ****************************************
   // interrupt pin
   // ****************************************
   assign irq_in = pin_sync_reg[`GPPI_PIN_IRQ] ^ inv_reg;

   // edge mode keeps a sticky bit; a new edge beats a same-cycle clear
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_prev_reg <= 1'b0;
         int_stat_reg <= 1'b0;
      end else begin
         irq_prev_reg <= irq_in;
         if (!edge_reg) begin
            int_stat_reg <= irq_in;
         end else if (irq_in && !irq_prev_reg) begin
            int_stat_reg <= 1'b1;
         end else if (int_clr) begin
            int_stat_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // pixel capture
   // ****************************************
   // blanking and invalid samples are dropped at the port
   assign take_pix = pix_mode && pclk_rise && pin_hold_reg[`GPPI_PIN_VALID]
                     && pin_hold_reg[`GPPI_PIN_LACT] && pin_hold_reg[`GPPI_PIN_FACT];

   // word: parity, cb, line start, field start, luma, chroma
   assign push_word = {pin_hold_reg[`GPPI_PIN_PARITY], pin_hold_reg[`GPPI_PIN_CB],
                       sol_reg, sof_reg, pin_hold_reg[15:0]};

   // strobe falling edges mark the next pixel taken
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         lstart_prev_reg <= 1'b1;
         fstart_prev_reg <= 1'b1;
         sol_reg         <= 1'b0;
         sof_reg         <= 1'b0;
         ovf_reg         <= 1'b0;
      end else begin
         if (pix_mode && pclk_rise) begin
            lstart_prev_reg <= pin_hold_reg[`GPPI_PIN_LSTART];
            fstart_prev_reg <= pin_hold_reg[`GPPI_PIN_FSTART];
         end
         if (pix_mode && pclk_rise && lstart_prev_reg && !pin_hold_reg[`GPPI_PIN_LSTART]) begin
            sol_reg <= 1'b1;
         end else if (take_pix) begin
            sol_reg <= 1'b0;
         end
         if (pix_mode && pclk_rise && fstart_prev_reg && !pin_hold_reg[`GPPI_PIN_FSTART]) begin
            sof_reg <= 1'b1;
         end else if (take_pix) begin
            sof_reg <= 1'b0;
         end
         // a lost pixel is flagged; the set wins over a clear
         if (take_pix && !fifo_ready) begin
            ovf_reg <= 1'b1;
         end else if (ovf_clr) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   gppi_fifo #(
      .WIDTH (`GPPI_PIX_W),
      .DEPTH (`GPPI_FIFO_DEPTH),
      .AW    (`GPPI_FIFO_AW)
   ) u_fifo (
      .clk_i       (CLK_I),
      .rst_i       (RST_I),
      .in_data_i   (push_word),
      .in_valid_i  (take_pix),
      .in_ready_o  (fifo_ready),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // output stage keeps PIX outputs on flops; a stalled sink fills the FIFO
   assign fifo_pop = fifo_valid && (!PIX_VALID_O || PIX_READY_I);

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PIX_DATA_O  <= 20'h00000;
         PIX_VALID_O <= 1'b0;
      end else if (!PIX_VALID_O || PIX_READY_I) begin
         PIX_DATA_O  <= fifo_data;
         PIX_VALID_O <= fifo_valid;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   // one cycle read latency; unmapped addresses read zero
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         REG_RDATA_O  <= 32'h00000000;
         REG_RVALID_O <= 1'b0;
         PORT_INT_O   <= 1'b0;
      end else begin
         REG_RVALID_O <= REG_RD_I;
         PORT_INT_O   <= int_stat_reg;
         if (REG_RD_I) begin
            if (win_hit) begin
               REG_RDATA_O <= {8'h00, read_pins};
            end else if (REG_ADDR_I == `GPPI_CTRL_ADDR) begin
               REG_RDATA_O <= {28'h0000000, edge_reg, inv_reg, mode_reg};
            end else if (REG_ADDR_I == `GPPI_OE_ADDR) begin
               REG_RDATA_O <= {8'h00, oe_reg};
            end else if (REG_ADDR_I == `GPPI_STAT_ADDR) begin
               REG_RDATA_O <= {29'h0000000, ~fifo_valid, ovf_reg, int_stat_reg};
            end else begin
               REG_RDATA_O <= 32'h00000000;
            end
         end
      end
   end
endmodule

// ### gppi_chk.sv
// Purpose: concurrent checks on the port top's pins
// Assumes: register writes mirrored here to predict pins
// Notes:   pin effects lag a write by two edges
`timescale 1ns/1ps
`include "gppi_defines.vh"
module gppi_chk (
   input wire        CLK_I,        // clock
   input wire        RST_I,        // reset
   input wire [8:0]  REG_ADDR_I,   // address
   input wire        REG_WR_I,     // write
   input wire        REG_RD_I,     // read
   input wire [31:0] REG_WDATA_I,  // wdata
   input wire [31:0] REG_RDATA_O,  // rdata
   input wire        REG_RVALID_O, // rvalid
   input wire [23:0] GPIO_I,       // pads in
   input wire [23:0] GPIO_O,       // pads out
   input wire [23:0] GPIO_OE_O,    // enables
   input wire        PCLK_I,       // port clock
   input wire [19:0] PIX_DATA_O,   // pixel
   input wire        PIX_VALID_O,  // valid
   input wire        PIX_READY_I,  // ready
   input wire        PORT_INT_O    // int status
);
   // ****
   // register mirror
   // ****
   reg  [1:0]  mode_reg;
   reg         inv_reg;
   reg         edge_reg;
   reg  [23:0] mask_reg;
   reg  [23:0] hold_reg;
   reg         pin_reg;
   reg  [2:0]  quiet_reg;
   wire        wr_ctrl = REG_WR_I && REG_ADDR_I == `GPPI_CTRL_ADDR;
   wire        win     = !REG_ADDR_I[8] && REG_ADDR_I[1:0] == 2'h0;
   wire [23:0] oe_exp  = (mode_reg == 2'h0) ? mask_reg : 24'h000000;
   // quiet counts edges since control or pin 8 moved; sync lag hides inside
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         {mode_reg, inv_reg, edge_reg, mask_reg, hold_reg, pin_reg, quiet_reg} <= 56'h0;
      end else begin
         if (wr_ctrl)
            {edge_reg, inv_reg, mode_reg} <= REG_WDATA_I[3:0];
         if (REG_WR_I && REG_ADDR_I == `GPPI_OE_ADDR)
            mask_reg <= REG_WDATA_I[23:0];
         if (REG_WR_I && win && mode_reg == 2'h0)
            hold_reg <= (REG_WDATA_I[23:0] & mask_reg) | (hold_reg & ~mask_reg);
         pin_reg <= GPIO_I[`GPPI_PIN_IRQ];
         if (wr_ctrl || pin_reg != GPIO_I[`GPPI_PIN_IRQ])
            quiet_reg <= 3'h0;
         else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
      end
   end
   // ****
   // properties
   // ****
   default clocking dclk @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_oe_reset: assert property ($fell(RST_I) |-> GPIO_OE_O == 24'h000000)
      else $error("enables not clear after reset");
   a_oe_follow: assert property (GPIO_OE_O == $past(oe_exp))
      else $error("enables differ from mask and mode");
   a_hold_drive: assert property (GPIO_O == $past(hold_reg))
      else $error("pin drive differs from holding value");
   a_rd_answer: assert property (REG_RD_I |=> REG_RVALID_O)
      else $error("read not answered next edge");
   a_rd_mask: assert property (REG_RD_I && REG_ADDR_I == `GPPI_OE_ADDR |=> REG_RDATA_O == {8'h00, $past(mask_reg)})
      else $error("mask readback wrong");
   a_win_upper: assert property (REG_RD_I && win |=> REG_RDATA_O[31:24] == 8'h00)
      else $error("window upper bits not zero");
   a_int_level: assert property (quiet_reg > 3'h5 && !edge_reg && mode_reg == 2'h0 |-> PORT_INT_O == (pin_reg ^ inv_reg))
      else $error("level status wrong");
   a_pix_hold: assert property (PIX_VALID_O && !PIX_READY_I |=> PIX_VALID_O && $stable(PIX_DATA_O))
      else $error("pixel word moved while stalled");
   c_pix_take: cover property (PIX_VALID_O && PIX_READY_I);
   c_pix_stall: cover property (PIX_VALID_O && !PIX_READY_I);
   c_int_rise: cover property ($rose(PORT_INT_O));
endmodule
bind gppi_top gppi_chk gppi_chk_inst (
   .CLK_I, .RST_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O,
   .GPIO_I, .GPIO_O, .GPIO_OE_O, .PCLK_I, .PIX_DATA_O, .PIX_VALID_O, .PIX_READY_I, .PORT_INT_O
);

// ### gppi_src.sv
// Purpose: synchronous pixel source on the port's far side
// Assumes: 800 ns port clock, still between lines
// Notes:   queues the words the sink should receive
`timescale 1ns/1ps
module gppi_src (
   output reg        pclk_o, // port clock
   output reg [23:0] pins_o  // source pins
);
   reg [19:0] exp_q [$];
   // idle low clock
   initial begin
      pclk_o = 1'b0;
      pins_o = 24'h000000;
   end
   // pins move while clock is low, taken at its rise
   task tick(input [23:0] p);
      begin
         pins_o = p;
         #400 pclk_o = 1'b1;
         #400 pclk_o = 1'b0;
      end
   endtask
   // strobe clock, n pixel clocks, one blanking clock
   task line(input integer n, input first, input par);
      integer    i;
      reg [7:0]  y;
      reg        v;
      begin
         y = 8'h00;
         tick({1'b0, !first, 3'b000, par, 1'b1, 17'h00000});
         for (i = 0; i < n; i = i + 1) begin
            y = 8'h10 + i[7:0];
            v = (i != 1); // one invalid pixel
            tick({3'b111, v, i[0], par, 2'b10, y, ~y});
            if (v)
               exp_q.push_back({par, i[0], i == 0, first && i == 0, y, ~y});
         end
         tick({5'b11000, par, 2'b10, ~y, y});
      end
   endtask
endmodule

// ### gppi_tb.sv
// Purpose: self-checking bench for the port top
// Assumes: pixel source model drives the pins in pixel mode
// Notes:   normal-mode table first, then hand-written cases
`timescale 1ns/1ps
`include "gppi_defines.vh"
module testbench;
   reg          clk_i   = 1'b0;
   reg          rst_i   = 1'b1;
   reg  [8:0]   addr    = 9'h000;
   reg          wr_s    = 1'b0;
   reg          rd_s    = 1'b0;
   reg  [31:0]  wdata   = 32'h00000000;
   reg  [23:0]  ext     = 24'h000000; // board levels
   reg          sel_src = 1'b0;
   reg          rdy     = 1'b1;
   wire [31:0]  rdata;
   wire         rvalid;
   wire [23:0]  gpio_o;
   wire [23:0]  gpio_oe;
   wire [23:0]  src_pins;
   wire         pclk;
   wire [19:0]  pix;
   wire         pix_v;
   wire         port_int;
   // wire level: enabled bits from the port, others from outside
   wire [23:0]  gpio_i = (gpio_o & gpio_oe) | ((sel_src ? src_pins : ext) & ~gpio_oe);
   integer      fail_count  = 0;
   integer      check_count = 0;
   integer      n;
   reg  [31:0]  r;
   reg  [31:0]  d;
   reg  [19:0]  w;
   reg  [23:0]  m;
   reg  [23:0]  e;
   reg  [23:0]  x;
   reg  [3:0]   we;
   reg  [6:0]   st;
   // mask, write flag, data, outside level, readback
   reg  [107:0] rows [0:4] = '{
      {24'h000000, 4'h1, 32'hFFAAAAAA, 24'h123456, 24'h123456},
      {24'hFFFFFF, 4'h0, 32'h00000000, 24'h654321, 24'h000000},
      {24'hFFFFFF, 4'h1, 32'hA5C33C5A, 24'h000000, 24'hC33C5A},
      {24'h0F0F0F, 4'h1, 32'h00FFFFFF, 24'h000000, 24'h0F0F0F},
      {24'hFFFFFF, 4'h0, 32'h00000000, 24'h000000, 24'hCF3F5F}};
   // control, clear, pin 8, status
   reg  [6:0]   isq [0:5] = '{7'h03, 7'h21, 7'h44, 7'h43, 7'h41, 7'h44};
   gppi_top gppi_top_inst (
      .CLK_I(clk_i), .RST_I(rst_i), .REG_ADDR_I(addr), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
      .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .GPIO_I(gpio_i),
      .GPIO_O(gpio_o), .GPIO_OE_O(gpio_oe), .PCLK_I(pclk), .PIX_DATA_O(pix),
      .PIX_VALID_O(pix_v), .PIX_READY_I(rdy), .PORT_INT_O(port_int));
   gppi_src gppi_src_inst (.pclk_o(pclk), .pins_o(src_pins));
   // 10 MHz clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task stop_test;
      begin
         if (fail_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] want);
      begin
         check_count = check_count + 1;
         if (seen !== want) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
         end
      end
   endtask
   // strobes are one cycle wide, launched at the falling edge
   task wr(input [8:0] a, input [31:0] v);
      begin
         @(negedge clk_i);
         addr = a;
         wdata = v;
         wr_s = 1'b1;
         @(negedge clk_i);
         wr_s = 1'b0;
      end
   endtask
   task rd(input [8:0] a, output [31:0] v);
      integer k;
      begin
         @(negedge clk_i);
         addr = a;
         rd_s = 1'b1;
         @(negedge clk_i);
         rd_s = 1'b0;
         for (k = 0; k < 4 && rvalid !== 1'b1; k = k + 1)
            @(posedge clk_i) #1;
         chk({31'h0, rvalid}, 32'h00000001);
         v = rdata;
      end
   endtask
   // sink takes words and compares them in order
   always @(posedge clk_i) begin
      if (pix_v === 1'b1 && rdy === 1'b1) begin
         w = 20'hFFFFF;
         if (gppi_src_inst.exp_q.size() > 0)
            w = gppi_src_inst.exp_q.pop_front();
         chk({12'h000, pix}, {12'h000, w});
      end
   end
   // hang guard, far beyond the expected run
   initial begin
      #1000000;
      fail_count = fail_count + 1;
      stop_test;
   end
   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      chk({8'h00, gpio_oe}, 32'h00000000);
      rd(`GPPI_OE_ADDR, r);
      chk(r, 32'h00000000);
      rd(`GPPI_CTRL_ADDR, r);
      chk({30'h0, r[1:0]}, 32'h00000000);
      rd(9'h1F0, r);
      chk(r, 32'h00000000);
      for (n = 0; n < 5; n = n + 1) begin
         {m, we, d, e, x} = rows[n];
         ext = e;
         wr(`GPPI_OE_ADDR, {8'h00, m});
         if (we[0])
            wr(9'h0FC, d);
         repeat (4) @(negedge clk_i);
         rd({1'b0, n[5:0], 2'b00}, r);
         chk(r, {8'h00, x});
      end
      // mode 2 releases every pin and ignores the window
      wr(`GPPI_CTRL_ADDR, 32'h00000002);
      repeat (4) @(negedge clk_i);
      chk({8'h00, gpio_oe}, 32'h00000000);
      wr(9'h000, 32'h00000000);
      wr(`GPPI_CTRL_ADDR, 32'h00000000);
      rd(9'h080, r);
      chk(r, 32'h00CF3F5F);
      wr(`GPPI_OE_ADDR, 32'h00000000);
      for (n = 0; n < 6; n = n + 1) begin
         st = isq[n];
         wr(`GPPI_CTRL_ADDR, {28'h0000000, st[6:3]});
         if (st[2])
            wr(`GPPI_STAT_ADDR, 32'h00000001);
         ext[8] = st[1];
         repeat (8) @(negedge clk_i);
         chk({31'h0, port_int}, {31'h0, st[0]});
      end
      wr(`GPPI_CTRL_ADDR, 32'h00000001);
      sel_src = 1'b1;
      gppi_src_inst.line(4, 1'b1, 1'b1);
      gppi_src_inst.line(4, 1'b0, 1'b1);
      // stall the sink: 17 words fit, the rest are lost
      @(negedge clk_i);
      rdy = 1'b0;
      gppi_src_inst.line(20, 1'b0, 1'b0);
      rd(`GPPI_STAT_ADDR, r);
      chk({31'h0, r[1]}, 32'h00000001);
      while (gppi_src_inst.exp_q.size() > 17)
         w = gppi_src_inst.exp_q.pop_back();
      rdy = 1'b1;
      repeat (60) @(negedge clk_i);
      chk(gppi_src_inst.exp_q.size(), 32'h00000000);
      wr(`GPPI_STAT_ADDR, 32'h00000002);
      rd(`GPPI_STAT_ADDR, r);
      chk({30'h0, r[2:1]}, 32'h00000002);
      // mid-run reset must drop enables even while pins are driven; mode is set back to normal before it
      wr(`GPPI_CTRL_ADDR, 32'h00000000);
      wr(`GPPI_OE_ADDR, 32'h00000F00);
      @(negedge clk_i);
      chk({8'h00, gpio_oe}, 32'h00000F00);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      chk({8'h00, gpio_oe}, 32'h00000000);
      rd(`GPPI_CTRL_ADDR, r);
      chk({30'h0, r[1:0]}, 32'h00000000);
      rd(`GPPI_OE_ADDR, r);
      chk(r, 32'h00000000);
      stop_test;
   end
endmodule
